// ### rcb_device.sv
// radio end: event sequencing, coexistence pins and bit stream output
// Summary of operation
// - activity high before and throughout each event
// - stream clock at 1 MHz, data synchronous
// - capture samples frame and data rising edge
// - packet shifted out serially, LSB first
// - frame mark high marks reception start
// - status shows rx or tx event
// - priority out for high priority events
// - early warning pulse ahead of event
// - inhibit input stops all radio activity
// - grant input says antenna is available
// - front end rx and tx selects
// - oscillator request turns on radio oscillator
// - external oscillator request for radio or system
// - reference clock out only while enabled
`timescale 1ns/1ps
module rcb_device
   import rcb_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic arst_n, // async reset, active low
   rcb_link_if.dev link, // pins toward partners
   input wire logic bit_stream_mode, // stream port enabled
   input wire logic evt_req, // start a radio event
   input wire logic evt_is_tx, // event transmits
   input wire logic evt_high_prio, // event is high priority
   input wire logic evt_end, // running event is done
   output logic evt_busy, // sequencer not idle
   output logic evt_aborted, // pulse: event stopped by inhibit
   input wire logic sw_status_take, // software owns status pin
   input wire logic sw_status_value, // status value from software
   input wire logic needs_ext_osc, // radio wants external osc
   input wire logic sys_on_radio_osc, // system clocked from radio osc
   input wire logic ref_clk_src, // reference clock from oscillator
   output logic rf_osc_on, // internal radio oscillator on
   input wire logic [BYTE_W-1:0] rx_wdata, // received packet byte
   input wire logic rx_wfirst, // byte opens a packet
   input wire logic rx_wvalid, // byte offered
   output logic rx_wready // byte accepted
);
   rcb_evt_t st_q;
   logic [9:0] cnt_q;
   logic tx_q;
   logic prio_q;
   logic inh_s1_q, inh_s2_q;
   logic gnt_s1_q, gnt_s2_q;
   logic osc_s1_q, osc_s2_q;
   logic ren_s1_q, ren_s2_q;
   logic ref_s1_q, ref_s2_q;
   logic [5:0] div_q;
   logic bclk_q;
   logic fall;
   logic [BYTE_W-1:0] sh_q;
   logic [3:0] bits_q;
   logic data_q;
   logic frame_q;
   logic can_stream;
   logic fifo_pop;
   logic [WORD_W-1:0] head;
   logic head_valid;
   logic active_q, status_q, pri_q, warn_q, rxs_q, txs_q, xosc_q, refo_q;
   logic abort_q;

   // two-flop synchronisers for pins from outside
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         inh_s1_q <= 1'b0;
         inh_s2_q <= 1'b0;
         gnt_s1_q <= 1'b0;
         gnt_s2_q <= 1'b0;
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         ren_s1_q <= 1'b0;
         ren_s2_q <= 1'b0;
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
      end else begin
         inh_s1_q <= link.radio_inhibit_in;
         inh_s2_q <= inh_s1_q;
         gnt_s1_q <= link.antenna_grant_in;
         gnt_s2_q <= gnt_s1_q;
         osc_s1_q <= link.internal_osc_request_in;
         osc_s2_q <= osc_s1_q;
         ren_s1_q <= link.ref_clock_out_enable;
         ren_s2_q <= ren_s1_q;
         ref_s1_q <= ref_clk_src;
         ref_s2_q <= ref_s1_q;
      end
   end

   // event sequencer: warning, lead-in, run
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= EVT_IDLE;
         cnt_q <= '0;
         tx_q <= 1'b0;
         prio_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         abort_q <= 1'b0;
         if (inh_s2_q && st_q != EVT_IDLE) begin
            st_q <= EVT_IDLE;
            abort_q <= 1'b1;
         end else begin
            case (st_q)
               EVT_IDLE: begin
                  if (evt_req && !inh_s2_q) begin
                     st_q <= EVT_WARN;
                     cnt_q <= WARN_LOAD;
                     tx_q <= evt_is_tx;
                     prio_q <= evt_high_prio;
                  end
               end
               EVT_WARN: begin
                  if (cnt_q == '0) begin
                     st_q <= EVT_LEAD;
                     cnt_q <= ACTIVE_LOAD;
                  end else begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
               EVT_LEAD: begin
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else if (!tx_q || gnt_s2_q) begin
                     st_q <= EVT_RUN;
                  end
               end
               EVT_RUN: begin
                  if (evt_end) begin
                     st_q <= EVT_IDLE;
                  end
               end
               default: begin
                  st_q <= EVT_IDLE;
               end
            endcase
         end
      end
   end

   // registered coexistence and front end pins
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         active_q <= 1'b0;
         status_q <= 1'b0;
         pri_q <= 1'b0;
         warn_q <= 1'b0;
         rxs_q <= 1'b0;
         txs_q <= 1'b0;
         xosc_q <= 1'b0;
         refo_q <= 1'b0;
      end else begin
         active_q <= (st_q == EVT_LEAD) || (st_q == EVT_RUN);
         if (sw_status_take) begin
            status_q <= sw_status_value;
         end else begin
            status_q <= st_q == EVT_RUN;
         end
         pri_q <= prio_q && st_q != EVT_IDLE && st_q != EVT_WARN;
         warn_q <= st_q == EVT_WARN;
         rxs_q <= st_q == EVT_RUN && !tx_q;
         txs_q <= st_q == EVT_RUN && tx_q;
         xosc_q <= needs_ext_osc || sys_on_radio_osc;
         refo_q <= ref_s2_q && ren_s2_q;
      end
   end

   // 1 MHz stream bit clock divider
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         div_q <= '0;
         bclk_q <= 1'b0;
      end else if (!bit_stream_mode) begin
         div_q <= '0;
         bclk_q <= 1'b0;
      end else begin
         div_q <= (div_q == DIV_LAST) ? 6'h00 : div_q + 6'h01;
         if (div_q == DIV_RISE - 6'h01) begin
            bclk_q <= 1'b1;
         end else if (div_q == DIV_LAST) begin
            bclk_q <= 1'b0;
         end
      end
   end

   // data changes on the falling edge, stable at the rising one
   assign fall = bit_stream_mode && div_q == DIV_LAST;
   assign can_stream = bit_stream_mode && st_q == EVT_RUN && !tx_q &&
      !inh_s2_q;
   assign fifo_pop = fall && can_stream && bits_q <= 4'h1;

   // packet buffer between receiver and stream shifter
   rcb_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .in_data({rx_wfirst, rx_wdata}),
      .in_valid(rx_wvalid),
      .in_ready(rx_wready),
      .out_data(head),
      .out_valid(head_valid),
      .out_ready(fifo_pop)
   );

   // stream shifter, least significant bit first
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sh_q <= '0;
         bits_q <= '0;
         data_q <= 1'b0;
         frame_q <= 1'b0;
      end else if (!can_stream) begin
         bits_q <= '0;
         data_q <= 1'b0;
         frame_q <= 1'b0;
      end else if (fall) begin
         if (bits_q > 4'h1) begin
            data_q <= sh_q[1];
            sh_q <= sh_q >> 1;
            bits_q <= bits_q - 4'h1;
            frame_q <= 1'b0;
         end else if (head_valid) begin
            sh_q <= head[BYTE_W-1:0];
            data_q <= head[0];
            frame_q <= head[BYTE_W];
            bits_q <= BITS_PER_BYTE;
         end else begin
            bits_q <= '0;
            data_q <= 1'b0;
            frame_q <= 1'b0;
         end
      end
   end

   // pin and user outputs
   assign link.radio_active_out = active_q;
   assign link.stream_bit_clock = bclk_q;
   assign link.stream_bit_data = data_q;
   assign link.stream_frame_mark = frame_q;
   assign link.radio_txrx_indicator = status_q;
   assign link.radio_priority_out = pri_q;
   assign link.radio_pre_event_warning = warn_q;
   assign link.fem_rx_select = rxs_q;
   assign link.fem_tx_select = txs_q;
   assign link.external_osc_request_out = xosc_q;
   assign link.ref_clock_out = refo_q;
   assign rf_osc_on = osc_s2_q;
   assign evt_busy = st_q != EVT_IDLE;
   assign evt_aborted = abort_q;
endmodule

// ### rcb_far_end.sv
// external partner end: coexistence control and stream capture
`timescale 1ns/1ps
module rcb_far_end
   import rcb_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic arst_n, // async reset, active low
   rcb_link_if.far link, // pins toward radio
   input wire logic inhibit_req, // stop the radio
   input wire logic grant_give, // antenna free for the radio
   input wire logic osc_req, // ask for radio oscillator
   input wire logic ref_out_en, // enable reference clock out
   output logic [SEEN_W-1:0] seen, // synchronised radio pins
   output logic [BYTE_W-1:0] cap_data, // captured byte
   output logic cap_first, // byte opened a frame
   output logic cap_valid // pulse: byte captured
);
   logic [2:0] s1_q, s2_q;
   logic clk_s3_q;
   logic [SEEN_W-1:0] seen1_q, seen2_q;
   logic rise;
   logic [BYTE_W-1:0] sh_q;
   logic [3:0] idx_q;
   logic first_q;
   logic [BYTE_W-1:0] cap_q;
   logic capf_q, capv_q;
   logic inh_q, gnt_q, osc_q, ren_q;

   // synchronisers for all radio pins except ref_clock_out
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         clk_s3_q <= 1'b0;
         seen1_q <= '0;
         seen2_q <= '0;
      end else begin
         s1_q <= {link.stream_frame_mark, link.stream_bit_data,
            link.stream_bit_clock};
         s2_q <= s1_q;
         clk_s3_q <= s2_q[0];
         seen1_q <= {link.external_osc_request_out, link.fem_tx_select,
            link.fem_rx_select, link.radio_pre_event_warning,
            link.radio_priority_out, link.radio_txrx_indicator,
            link.radio_active_out};
         seen2_q <= seen1_q;
      end
   end

   assign rise = s2_q[0] && !clk_s3_q;

   // sample frame and data on each rising stream clock edge
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sh_q <= '0;
         idx_q <= '0;
         first_q <= 1'b0;
         cap_q <= '0;
         capf_q <= 1'b0;
         capv_q <= 1'b0;
      end else begin
         capv_q <= 1'b0;
         if (rise) begin
            if (s2_q[2] || idx_q == '0) begin
               sh_q <= {s2_q[1], sh_q[BYTE_W-1:1]};
               first_q <= s2_q[2];
               idx_q <= 4'h1;
            end else if (idx_q == BITS_PER_BYTE - 4'h1) begin
               cap_q <= {s2_q[1], sh_q[BYTE_W-1:1]};
               capf_q <= first_q;
               capv_q <= 1'b1;
               idx_q <= '0;
            end else begin
               sh_q <= {s2_q[1], sh_q[BYTE_W-1:1]};
               idx_q <= idx_q + 4'h1;
            end
         end
      end
   end

   // registered control pins toward the radio
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         inh_q <= 1'b0;
         gnt_q <= 1'b0;
         osc_q <= 1'b0;
         ren_q <= 1'b0;
      end else begin
         inh_q <= inhibit_req;
         gnt_q <= grant_give;
         osc_q <= osc_req;
         ren_q <= ref_out_en;
      end
   end

   assign link.radio_inhibit_in = inh_q;
   assign link.antenna_grant_in = gnt_q;
   assign link.internal_osc_request_in = osc_q;
   assign link.ref_clock_out_enable = ren_q;
   assign seen = seen2_q;
   assign cap_data = cap_q;
   assign cap_first = capf_q;
   assign cap_valid = capv_q;
endmodule

// ### rcb_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module rcb_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic [WIDTH-1:0] in_data, // write word
   input wire logic in_valid, // write request
   output logic in_ready, // room available
   output logic [WIDTH-1:0] out_data, // head word
   output logic out_valid, // head word present
   input wire logic out_ready // head word taken
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   // full when pointers differ only in the wrap bit
   assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_q != rd_q;
   assign out_data = mem_q[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage array
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// ### rcb_link_if.sv
// pins between the radio device and its external partners
`timescale 1ns/1ps
interface rcb_link_if;
   logic radio_active_out;
   logic stream_bit_clock;
   logic stream_bit_data;
   logic stream_frame_mark;
   logic radio_txrx_indicator;
   logic radio_priority_out;
   logic radio_pre_event_warning;
   logic radio_inhibit_in;
   logic antenna_grant_in;
   logic fem_rx_select;
   logic fem_tx_select;
   logic internal_osc_request_in;
   logic external_osc_request_out;
   logic ref_clock_out_enable;
   logic ref_clock_out;
   // documented radio end
   modport dev (
      output radio_active_out, stream_bit_clock, stream_bit_data,
      output stream_frame_mark, radio_txrx_indicator, radio_priority_out,
      output radio_pre_event_warning, fem_rx_select, fem_tx_select,
      output external_osc_request_out, ref_clock_out,
      input radio_inhibit_in, antenna_grant_in, internal_osc_request_in,
      input ref_clock_out_enable
   );
   // external radio, front end and capture logic
   modport far (
      input radio_active_out, stream_bit_clock, stream_bit_data,
      input stream_frame_mark, radio_txrx_indicator, radio_priority_out,
      input radio_pre_event_warning, fem_rx_select, fem_tx_select,
      input external_osc_request_out, ref_clock_out,
      output radio_inhibit_in, antenna_grant_in, internal_osc_request_in,
      output ref_clock_out_enable
   );
endinterface

// ### rcb_pkg.sv
// shared constants for the radio coexistence and bit stream port
package rcb_pkg;
   // system clock and stream bit clock
   localparam int CLK_SYS_HZ = 50_000_000;
   localparam int STREAM_BIT_HZ = 1_000_000;
   localparam int BIT_CYCLES = CLK_SYS_HZ / STREAM_BIT_HZ;
   localparam int HALF_CYCLES = BIT_CYCLES / 2;
   localparam logic [5:0] DIV_LAST = 6'(BIT_CYCLES - 1);
   localparam logic [5:0] DIV_RISE = 6'(HALF_CYCLES);
   // lead times ahead of a radio event, in ns
   localparam int WARN_LEAD_NS = 10_000;
   localparam int ACTIVE_LEAD_NS = 1_000;
   localparam int WARN_CYCLES = (WARN_LEAD_NS * (CLK_SYS_HZ / 1_000_000)
      + 999) / 1000;
   localparam int ACTIVE_CYCLES = (ACTIVE_LEAD_NS * (CLK_SYS_HZ / 1_000_000)
      + 999) / 1000;
   localparam logic [9:0] WARN_LOAD = 10'(WARN_CYCLES - 1);
   localparam logic [9:0] ACTIVE_LOAD = 10'(ACTIVE_CYCLES - 1);
   // stream word: data byte plus start-of-frame flag
   localparam int BYTE_W = 8;
   localparam int WORD_W = BYTE_W + 1;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // bit positions of the far end observation vector
   localparam int SEEN_W = 7;
   localparam int SEEN_ACTIVE = 0;
   localparam int SEEN_STATUS = 1;
   localparam int SEEN_PRIO = 2;
   localparam int SEEN_WARN = 3;
   localparam int SEEN_RX_SEL = 4;
   localparam int SEEN_TX_SEL = 5;
   localparam int SEEN_EXT_OSC = 6;
   // radio event sequencer states
   typedef enum logic [3:0] {
      EVT_IDLE = 4'b0001,
      EVT_WARN = 4'b0010,
      EVT_LEAD = 4'b0100,
      EVT_RUN = 4'b1000
   } rcb_evt_t;
endpackage

// ### rcb_sva.sv
// concurrent checks on the pins between radio end and far end
`timescale 1ns/1ps
module rcb_sva (
   input wire logic clk_sys, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic radio_active_out, // activity pin
   input wire logic stream_bit_clock, // stream clock pin
   input wire logic stream_bit_data, // stream data pin
   input wire logic stream_frame_mark, // frame mark pin
   input wire logic radio_priority_out, // priority pin
   input wire logic radio_pre_event_warning, // warning pin
   input wire logic radio_inhibit_in, // inhibit pin
   input wire logic fem_rx_select, // front end rx select
   input wire logic fem_tx_select, // front end tx select
   input wire logic ref_clock_out_enable, // ref clock enable pin
   input wire logic ref_clock_out // ref clock pin
);
   logic [9:0] warn_q;
   logic [5:0] hi_q;
   logic [5:0] fr_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   // run lengths of warning, stream clock high and frame mark
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         warn_q <= 10'h000;
         hi_q <= 6'h00;
         fr_q <= 6'h00;
      end else begin
         warn_q <= radio_pre_event_warning ? warn_q + 10'h001 : 10'h000;
         hi_q <= stream_bit_clock ? hi_q + 6'h01 : 6'h00;
         fr_q <= stream_frame_mark ? fr_q + 6'h01 : 6'h00;
      end
   end
   property p_act_rise;
      $rose(radio_active_out) |-> $past(radio_pre_event_warning);
   endproperty
   a_act_rise: assert property (p_act_rise)
      else $error("activity rose without a warning before it");
   property p_warn_len; warn_q <= 10'h1F4; endproperty
   a_warn_len: assert property (p_warn_len)
      else $error("warning held longer than its lead time");
   property p_sel_excl; !(fem_rx_select && fem_tx_select); endproperty
   a_sel_excl: assert property (p_sel_excl)
      else $error("rx and tx selects high together");
   property p_sel_act;
      fem_rx_select || fem_tx_select |-> radio_active_out;
   endproperty
   a_sel_act: assert property (p_sel_act)
      else $error("front end select outside activity");
   property p_prio; radio_priority_out |-> radio_active_out; endproperty
   a_prio: assert property (p_prio)
      else $error("priority without activity");
   property p_clk_hi; hi_q <= 6'h19; endproperty
   a_clk_hi: assert property (p_clk_hi)
      else $error("stream clock high too long");
   property p_stable;
      $rose(stream_bit_clock) |->
         $stable(stream_bit_data) && $stable(stream_frame_mark);
   endproperty
   a_stable: assert property (p_stable)
      else $error("stream bits change at the clock rise");
   property p_frame; fr_q <= 6'h32; endproperty
   a_frame: assert property (p_frame)
      else $error("frame mark longer than one bit");
   property p_inhibit;
      radio_inhibit_in [*6] |->
         !radio_active_out && !fem_rx_select && !fem_tx_select;
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("radio active while inhibited");
   property p_ref; (!ref_clock_out_enable) [*6] |-> !ref_clock_out; endproperty
   a_ref: assert property (p_ref)
      else $error("reference clock out while disabled");
endmodule

// ### tb.sv
// self-checking bench joining the radio end to the far end
`timescale 1ns/1ps
module tb;
   import rcb_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic bit_stream_mode = 1'b0;
   logic evt_req = 1'b0;
   logic evt_is_tx = 1'b0;
   logic evt_high_prio = 1'b0;
   logic evt_end = 1'b0;
   logic sw_status_take = 1'b0;
   logic sw_status_value = 1'b0;
   logic needs_ext_osc = 1'b0;
   logic sys_on_radio_osc = 1'b0;
   logic ref_clk_src = 1'b0;
   logic [BYTE_W-1:0] rx_wdata = 8'h00;
   logic rx_wfirst = 1'b0;
   logic rx_wvalid = 1'b0;
   logic inhibit_req = 1'b0;
   logic grant_give = 1'b0;
   logic osc_req = 1'b0;
   logic ref_out_en = 1'b0;
   logic evt_busy, evt_aborted, rf_osc_on, rx_wready;
   logic [SEEN_W-1:0] seen;
   logic [BYTE_W-1:0] cap_data;
   logic cap_first, cap_valid;
   logic [6:0] mon;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;
   rcb_link_if link ();
   rcb_device rcb_device_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .link(link), .bit_stream_mode(bit_stream_mode), .evt_req(evt_req),
      .evt_is_tx(evt_is_tx), .evt_high_prio(evt_high_prio),
      .evt_end(evt_end), .evt_busy(evt_busy), .evt_aborted(evt_aborted),
      .sw_status_take(sw_status_take), .sw_status_value(sw_status_value),
      .needs_ext_osc(needs_ext_osc), .sys_on_radio_osc(sys_on_radio_osc),
      .ref_clk_src(ref_clk_src), .rf_osc_on(rf_osc_on),
      .rx_wdata(rx_wdata), .rx_wfirst(rx_wfirst), .rx_wvalid(rx_wvalid),
      .rx_wready(rx_wready));
   rcb_far_end rcb_far_end_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .link(link), .inhibit_req(inhibit_req), .grant_give(grant_give),
      .osc_req(osc_req), .ref_out_en(ref_out_en), .seen(seen),
      .cap_data(cap_data), .cap_first(cap_first), .cap_valid(cap_valid));
   rcb_sva rcb_sva_inst (.clk_sys(clk_sys), .arst_n(arst_n),
      .radio_active_out(link.radio_active_out),
      .stream_bit_clock(link.stream_bit_clock),
      .stream_bit_data(link.stream_bit_data),
      .stream_frame_mark(link.stream_frame_mark),
      .radio_priority_out(link.radio_priority_out),
      .radio_pre_event_warning(link.radio_pre_event_warning),
      .radio_inhibit_in(link.radio_inhibit_in),
      .fem_rx_select(link.fem_rx_select), .fem_tx_select(link.fem_tx_select),
      .ref_clock_out_enable(link.ref_clock_out_enable),
      .ref_clock_out(link.ref_clock_out));
   // watched flags: 0 clk, 1 warn, 2 active, 3 rx, 4 tx, 5 abort, 6 capture
   assign mon = {cap_valid, evt_aborted, link.fem_tx_select,
      link.fem_rx_select, link.radio_active_out,
      link.radio_pre_event_warning, link.stream_bit_clock};
   // clock and hang guard
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   task automatic final_report();
      if (num_errors == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // waits for a watched flag, counting edges until it shows
   task automatic wait_bit(input int b, input logic v, input int lim,
      output int n);
      n = 0;
      while (mon[b] !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      chk({8'h00, mon[b]}, {8'h00, v});
   endtask
   task automatic t_reset();
      chk({2'b00, seen}, 9'h000);
      chk({7'h00, rx_wready, evt_busy}, 9'h002);
      chk({8'h00, link.stream_bit_clock}, 9'h000);
   endtask
   // fill fifo past full, then stream it out in an rx event
   task automatic t_rx_stream();
      int n;
      logic [7:0] b;
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_sys);
         rx_wdata <= (i == 8) ? 8'hFF : 8'(8'h1D + 8'h25 * i);
         rx_wfirst <= (i == 0);
         rx_wvalid <= 1'b1;
      end
      @(posedge clk_sys);
      chk({8'h00, rx_wready}, 9'h000);
      rx_wvalid <= 1'b0;
      evt_high_prio <= 1'b1;
      evt_req <= 1'b1;
      @(posedge clk_sys);
      evt_req <= 1'b0;
      wait_bit(1, 1'b1, 10, n);
      wait_bit(1, 1'b0, 600, n);
      chk(9'(n), 9'h1F4);
      chk({7'h00, mon[2], link.radio_priority_out}, 9'h003);
      wait_bit(3, 1'b1, 60, n);
      chk({7'h00, link.radio_txrx_indicator, mon[4]}, 9'h002);
      wait_bit(0, 1'b0, 60, n);
      wait_bit(0, 1'b1, 60, n);
      wait_bit(0, 1'b0, 60, n);
      chk(9'(n), 9'h019);
      wait_bit(0, 1'b1, 60, n);
      chk(9'(n), 9'h019);
      for (int i = 0; i < 8; i++) begin
         wait_bit(6, 1'b1, 500, n);
         b = 8'(8'h1D + 8'h25 * i);
         chk({cap_first, cap_data}, {i == 0, b});
         @(posedge clk_sys);
      end
      chk({8'h00, rx_wready}, 9'h001);
      evt_end <= 1'b1;
      @(posedge clk_sys);
      evt_end <= 1'b0;
      wait_bit(2, 1'b0, 5, n);
      repeat (4) @(posedge clk_sys);
      chk({2'b00, seen}, 9'h000);
   endtask
   // tx event waits for grant, then is cut off by inhibit
   task automatic t_tx_inhibit();
      int n;
      evt_is_tx <= 1'b1;
      evt_high_prio <= 1'b0;
      evt_req <= 1'b1;
      @(posedge clk_sys);
      evt_req <= 1'b0;
      wait_bit(2, 1'b1, 600, n);
      chk({8'h00, link.radio_priority_out}, 9'h000);
      repeat (200) @(posedge clk_sys);
      chk({2'b00, seen}, 9'h001);
      chk({8'h00, mon[4]}, 9'h000);
      grant_give <= 1'b1;
      wait_bit(4, 1'b1, 20, n);
      chk({7'h00, mon[3], link.radio_txrx_indicator}, 9'h001);
      inhibit_req <= 1'b1;
      wait_bit(5, 1'b1, 10, n);
      wait_bit(2, 1'b0, 5, n);
      evt_req <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({8'h00, evt_busy}, 9'h000);
      evt_req <= 1'b0;
      inhibit_req <= 1'b0;
      grant_give <= 1'b0;
   endtask
   // software drives the status pin
   task automatic t_status();
      sw_status_take <= 1'b1;
      sw_status_value <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk({8'h00, link.radio_txrx_indicator}, 9'h001);
      sw_status_value <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({8'h00, link.radio_txrx_indicator}, 9'h000);
      sw_status_take <= 1'b0;
   endtask
   // oscillator requests and gated reference clock
   task automatic t_osc();
      osc_req <= 1'b1;
      needs_ext_osc <= 1'b1;
      ref_clk_src <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({6'h00, rf_osc_on, link.external_osc_request_out,
         link.ref_clock_out}, 9'h006);
      osc_req <= 1'b0;
      needs_ext_osc <= 1'b0;
      sys_on_radio_osc <= 1'b1;
      ref_out_en <= 1'b1;
      repeat (8) @(posedge clk_sys);
      chk({6'h00, rf_osc_on, link.external_osc_request_out,
         link.ref_clock_out}, 9'h003);
      sys_on_radio_osc <= 1'b0;
      ref_clk_src <= 1'b0;
      repeat (8) @(posedge clk_sys);
      chk({6'h00, rf_osc_on, link.external_osc_request_out,
         link.ref_clock_out}, 9'h000);
   endtask
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      bit_stream_mode <= 1'b1;
      t_rx_stream();
      t_tx_inhibit();
      t_status();
      t_osc();
      final_report();
   end
endmodule
